// file: logic/dmc_mode_ctrl.sv
// dram mode control registers and the dram cycle sequencer they steer
// assumes host decode, pci decode and avalon master share clk;
// the strap pin and the memory data pins are asynchronous
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dmc_consts.svh"

module dmc_mode_ctrl
  import dmc_pkg::*;
#(
  parameter int AW = 10,
  parameter int DW = 64
)
(
  // clock, reset, enable
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clkEn,
  // avalon-mm register slave
  input  wire logic [AW-1:0] avsAddress,
  input  wire logic          avsRead,
  input  wire logic          avsWrite,
  input  wire logic [31:0]   avsWritedata,
  input  wire logic [3:0]    avsByteenable,
  output logic      [31:0]   avsReaddata,
  output logic               avsWaitrequest,
  // host cycle request and decode
  input  wire logic          hostReq,
  input  wire logic [31:0]   hostAddr,
  input  wire logic          hostWrite,
  input  wire logic [DW-1:0] hostWdata,
  input  wire logic          decodeDone,
  input  dmc_target_e        decodeTarget,
  output logic               hostDone,
  output logic      [DW-1:0] hostRdata,
  output logic               hostToPci,
  output logic               specCancel,
  // pci master claim
  input  wire logic          pciReq,
  input  wire logic [31:0]   pciAddr,
  input  wire logic          pciDramHit,
  output logic               pciDevsel,
  // reset strap pin
  input  wire logic          hostAddressStrapLine,
  // dram pins
  output logic      [11:2]   memoryAddressLines,
  output logic      [1:0]    lowAddrCopyA,
  output logic      [1:0]    lowAddrCopyB,
  output logic               rasN,
  output logic               casN,
  output logic               memoryWriteEnableN,
  input  wire logic [DW-1:0] memoryDataLinesIn,
  output logic      [DW-1:0] memoryDataLinesOut,
  output logic               memoryDataLinesOeN,
  // pad controls
  output logic               lowAddrDrive12mA,
  output logic               upperAddrDrive12mA,
  output logic               edoDetectTiming
);
  typedef struct packed {
    dmc_state_e    st;
    logic          waitReq;
    logic [7:0]    rdData;
    logic [7:0]    extCtrl;
    logic [7:0]    ctrl;
    logic          strapPending;
    logic          strapS1;
    logic          strapS2;
    logic [DW-1:0] rdS1;
    logic [DW-1:0] rdS2;
    logic [31:0]   addr;
    logic          isWrite;
    logic [DW-1:0] wdata;
    logic          spec;
    logic [1:0]    tCnt;
    logic          refPend;
    logic [11:0]   memAddr;
    logic          rasN;
    logic          casN;
    logic          weN;
    logic          oeN;
    logic [DW-1:0] mdOut;
    logic [DW-1:0] hostRdata;
    logic          hostDone;
    logic          hostToPci;
    logic          specCancel;
    logic          pciDevsel;
  } dmc_ctrl_s;

  dmc_ctrl_s q_reg;
  dmc_ctrl_s q_next;
  dmc_cfg_if cfg ();

  logic [1:0] holeSel;
  logic       speculative_leadoff_en;
  logic       turnaround_insert_en;
  logic       edo;
  logic       hostHole;
  logic       dramOk;
  logic       toPci;

  function automatic logic regHit(input logic [AW-1:0] a,
                                  input logic [7:0]    idx);
    return a == AW'({idx, 2'b00});
  endfunction

  function automatic logic [7:0] regRead(input logic [AW-1:0] a,
                                         input dmc_ctrl_s     s);
    logic [7:0] v;
    v = 8'h00;
    if (regHit(a, `DMC_IDX_EXT_CTRL))
      v = s.extCtrl & `DMC_EXT_MASK;
    else if (regHit(a, `DMC_IDX_CTRL))
      v = s.ctrl & `DMC_CTRL_MASK;
    return v;
  endfunction

  assign holeSel = q_reg.ctrl[`DMC_HOLE_MSB:`DMC_HOLE_LSB];
  assign speculative_leadoff_en     = q_reg.extCtrl[`DMC_BIT_SLE];
  assign turnaround_insert_en    = q_reg.extCtrl[`DMC_BIT_TURNAROUND_INSERT_EN];
  assign edo     = q_reg.ctrl[`DMC_BIT_EDO];
  assign hostHole = dmc_hole_hit(holeSel, q_reg.addr);
  assign dramOk  = (decodeTarget == DMC_TGT_DRAM) && !hostHole;
  assign toPci   = (decodeTarget == DMC_TGT_PCI) || hostHole;

  // the mux looks at the incoming address while idle so a
  // speculative row can leave in the same cycle the request lands
  assign cfg.addr = (q_reg.st == DMC_ST_IDLE) ? hostAddr : q_reg.addr;
  assign cfg.highDensity = q_reg.extCtrl[`DMC_BIT_HDM];
  assign cfg.refreshRate = q_reg.ctrl[`DMC_RATE_MSB:`DMC_RATE_LSB];

  dmc_refresh_timer u_timer (
    .clk   (clk),
    .reset (reset),
    .clkEn (clkEn),
    .cfg   (cfg.timer)
  );

  dmc_addr_mux u_mux (
    .cfg (cfg.mux)
  );

  always_comb
  begin
    q_next = q_reg;
    q_next.hostDone   = 1'b0;
    q_next.hostToPci  = 1'b0;
    q_next.specCancel = 1'b0;
    q_next.pciDevsel  = 1'b0;
    q_next.strapS1 = hostAddressStrapLine;
    q_next.strapS2 = q_reg.strapS1;
    q_next.rdS1    = memoryDataLinesIn;
    q_next.rdS2    = q_reg.rdS1;

    // strap is taken on the first edge after reset release
    if (q_reg.strapPending)
    begin
      q_next.ctrl[0]      = ~q_reg.strapS2;
      q_next.strapPending = 1'b0;
    end

    // one wait state per access; writes land on the edge that
    // the master sees waitrequest low, after the strap load
    q_next.waitReq = 1'b1;
    if ((avsRead || avsWrite) && q_reg.waitReq)
    begin
      q_next.waitReq = 1'b0;
      q_next.rdData  = regRead(avsAddress, q_reg);
    end
    if (avsWrite && !q_reg.waitReq && avsByteenable[0])
    begin
      if (regHit(avsAddress, `DMC_IDX_EXT_CTRL))
        q_next.extCtrl = avsWritedata[7:0] & `DMC_EXT_MASK;
      if (regHit(avsAddress, `DMC_IDX_CTRL))
        q_next.ctrl = avsWritedata[7:0] & `DMC_CTRL_MASK;
    end

    if (pciReq && pciDramHit && !dmc_hole_hit(holeSel, pciAddr))
      q_next.pciDevsel = 1'b1;

    case (q_reg.st)
      DMC_ST_IDLE:
      begin
        if (q_reg.refPend)
        begin
          q_next.refPend = 1'b0;
          q_next.casN    = 1'b0;
          q_next.st      = DMC_ST_REF_CAS;
        end
        else if (hostReq)
        begin
          q_next.addr    = hostAddr;
          q_next.isWrite = hostWrite;
          q_next.wdata   = hostWdata;
          // only reads may start early; write data must not move
          if (speculative_leadoff_en && !hostWrite)
          begin
            q_next.spec    = 1'b1;
            q_next.rasN    = 1'b0;
            q_next.memAddr = cfg.rowAddr;
            q_next.st      = DMC_ST_ROW;
          end
          else
            q_next.st = DMC_ST_DECODE;
        end
      end
      DMC_ST_DECODE:
      begin
        if (decodeDone)
        begin
          if (dramOk)
          begin
            q_next.rasN    = 1'b0;
            q_next.memAddr = cfg.rowAddr;
            q_next.st      = DMC_ST_ROW;
          end
          else
          begin
            q_next.hostToPci = toPci;
            q_next.st        = DMC_ST_IDLE;
          end
        end
      end
      DMC_ST_ROW:
      begin
        q_next.casN    = 1'b0;
        q_next.memAddr = cfg.colAddr;
        q_next.weN     = ~q_reg.isWrite;
        if (q_reg.isWrite)
          q_next.tCnt = turnaround_insert_en ? 2'h2 : 2'h1;
        else
          q_next.tCnt = edo ? 2'h2 : 2'h1;
        q_next.st = DMC_ST_COL;
      end
      DMC_ST_COL:
      begin
        if (q_reg.tCnt > 2'h1)
          q_next.tCnt = q_reg.tCnt - 2'h1;
        else if (q_reg.isWrite)
        begin
          q_next.oeN   = 1'b0;
          q_next.mdOut = q_reg.wdata;
          q_next.st    = DMC_ST_DATA;
        end
        else
        begin
          q_next.tCnt = `DMC_SYNC_DEPTH;
          q_next.st   = DMC_ST_RDWAIT;
        end
      end
      DMC_ST_DATA:
      begin
        q_next.oeN      = 1'b1;
        q_next.weN      = 1'b1;
        q_next.casN     = 1'b1;
        q_next.rasN     = 1'b1;
        q_next.hostDone = 1'b1;
        q_next.st       = DMC_ST_IDLE;
      end
      DMC_ST_RDWAIT:
      begin
        // data cannot be handed over until the decode agrees
        if (q_reg.tCnt > 2'h1)
          q_next.tCnt = q_reg.tCnt - 2'h1;
        else if (!q_reg.spec)
        begin
          q_next.hostRdata = q_reg.rdS2;
          q_next.hostDone  = 1'b1;
          q_next.casN      = 1'b1;
          q_next.rasN      = 1'b1;
          q_next.st        = DMC_ST_IDLE;
        end
      end
      DMC_ST_REF_CAS:
      begin
        q_next.rasN = 1'b0;
        q_next.st   = DMC_ST_REF_RAS;
      end
      DMC_ST_REF_RAS:
      begin
        q_next.rasN = 1'b1;
        q_next.casN = 1'b1;
        q_next.st   = DMC_ST_IDLE;
      end
      default:
        q_next.st = DMC_ST_IDLE;
    endcase

    if (q_reg.spec && decodeDone && q_reg.st != DMC_ST_IDLE)
    begin
      if (dramOk)
        q_next.spec = 1'b0;
      else
      begin
        q_next.spec       = 1'b0;
        q_next.specCancel = 1'b1;
        q_next.hostToPci  = toPci;
        q_next.rasN       = 1'b1;
        q_next.casN       = 1'b1;
        q_next.weN        = 1'b1;
        q_next.oeN        = 1'b1;
        q_next.st         = DMC_ST_IDLE;
      end
    end

    // a refresh tick in the cycle its pending flag is taken wins
    if (cfg.refreshPulse)
      q_next.refPend = 1'b1;

    if (reset)
    begin
      q_next = '0;
      q_next.st           = DMC_ST_IDLE;
      q_next.waitReq      = 1'b1;
      q_next.extCtrl      = `DMC_EXT_RESET;
      q_next.ctrl         = `DMC_CTRL_RESET;
      q_next.strapPending = 1'b1;
      q_next.rasN         = 1'b1;
      q_next.casN         = 1'b1;
      q_next.weN          = 1'b1;
      q_next.oeN          = 1'b1;
      q_next.strapS1      = hostAddressStrapLine;
      q_next.strapS2      = q_reg.strapS1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || clkEn)
      q_reg <= q_next;
  end

  assign avsReaddata        = {24'h000000, q_reg.rdData};
  assign avsWaitrequest     = q_reg.waitReq;
  assign hostDone           = q_reg.hostDone;
  assign hostRdata          = q_reg.hostRdata;
  assign hostToPci          = q_reg.hostToPci;
  assign specCancel         = q_reg.specCancel;
  assign pciDevsel          = q_reg.pciDevsel;
  assign memoryAddressLines = q_reg.memAddr[11:2];
  assign lowAddrCopyA       = q_reg.memAddr[1:0];
  assign lowAddrCopyB       = q_reg.memAddr[1:0];
  assign rasN               = q_reg.rasN;
  assign casN               = q_reg.casN;
  assign memoryWriteEnableN = q_reg.weN;
  assign memoryDataLinesOut = q_reg.mdOut;
  assign memoryDataLinesOeN = q_reg.oeN;
  // pads only take a strength code; the ma/we buffers live outside
  assign lowAddrDrive12mA   = q_reg.extCtrl[`DMC_BIT_DRV_LOW];
  assign upperAddrDrive12mA = q_reg.extCtrl[`DMC_BIT_DRV_UP];
  assign edoDetectTiming    = q_reg.ctrl[`DMC_BIT_EDO];
endmodule

// file: pkg/dmc_consts.svh
// register indices, field positions, reset values and timing counts
// of the dram mode control block; included by the package and the top
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

`define DMC_IDX_EXT_CTRL   8'h56
`define DMC_IDX_CTRL       8'h57
`define DMC_EXT_RESET      8'h00
`define DMC_CTRL_RESET     8'h01
`define DMC_EXT_MASK       8'h1f
`define DMC_CTRL_MASK      8'hcf

`define DMC_BIT_SLE        4
`define DMC_BIT_TURNAROUND_INSERT_EN       3
`define DMC_BIT_DRV_LOW    2
`define DMC_BIT_DRV_UP     1
`define DMC_BIT_HDM        0
`define DMC_HOLE_MSB       7
`define DMC_HOLE_LSB       6
`define DMC_BIT_EDO        3
`define DMC_RATE_MSB       2
`define DMC_RATE_LSB       0

`define DMC_HOLE_LOW       2'h1
`define DMC_HOLE_HIGH      2'h2
`define DMC_HOLE_LOW_BASE  32'h0008_0000
`define DMC_HOLE_LOW_END   32'h000a_0000
`define DMC_HOLE_HIGH_BASE 32'h00f0_0000
`define DMC_HOLE_HIGH_END  32'h0100_0000

`define DMC_RATE_50        3'h1
`define DMC_RATE_60        3'h2
`define DMC_RATE_66        3'h3
`define DMC_REFRESH_NS     15600
`define DMC_REF_CYCLES(mhz) ((`DMC_REFRESH_NS * (mhz)) / 1000)

`define DMC_COL_LSB        3
`define DMC_ROW_LSB        15
`define DMC_ROW11_STD      26
`define DMC_ROW11_HDM      27
`define DMC_SYNC_DEPTH     2'h2

`endif

// file: pkg/dmc_pkg.sv
// types and the shared hole decoder of the dram mode control block
// assumes dmc_consts.svh is on the include path
package dmc_pkg;
  `include "dmc_consts.svh"

  typedef enum logic [1:0] {
    DMC_TGT_CACHE = 2'b00,
    DMC_TGT_DRAM  = 2'b01,
    DMC_TGT_PCI   = 2'b10
  } dmc_target_e;

  typedef enum logic [3:0] {
    DMC_ST_IDLE    = 4'b0000,
    DMC_ST_DECODE  = 4'b0001,
    DMC_ST_ROW     = 4'b0010,
    DMC_ST_COL     = 4'b0011,
    DMC_ST_DATA    = 4'b0100,
    DMC_ST_RDWAIT  = 4'b0101,
    DMC_ST_REF_CAS = 4'b0110,
    DMC_ST_REF_RAS = 4'b0111
  } dmc_state_e;

  // reserved hole code decodes as no hole
  function automatic logic dmc_hole_hit(input logic [1:0]  sel,
                                        input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    case (sel)
      `DMC_HOLE_LOW:  hit = (a >= `DMC_HOLE_LOW_BASE) &&
                            (a < `DMC_HOLE_LOW_END);
      `DMC_HOLE_HIGH: hit = (a >= `DMC_HOLE_HIGH_BASE) &&
                            (a < `DMC_HOLE_HIGH_END);
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction
endpackage

// file: pkg/dmc_cfg_if.sv
// carrier between the controller and its refresh timer and address mux
// assumes all three sit on one clock
`timescale 1ns/1ps
interface dmc_cfg_if;
  logic [2:0]  refreshRate;
  logic        highDensity;
  logic        refreshPulse;
  logic [31:0] addr;
  logic [11:0] rowAddr;
  logic [11:0] colAddr;

  modport ctrl  (output refreshRate, highDensity, addr,
                 input  refreshPulse, rowAddr, colAddr);
  modport timer (input  refreshRate, output refreshPulse);
  modport mux   (input  highDensity, addr, output rowAddr, colAddr);
endinterface

// file: logic/dmc_refresh_timer.sv
// refresh pacer: one pulse per refresh interval at the chosen bus rate
// assumes the rate field comes from the control register
`timescale 1ns/1ps
`include "dmc_consts.svh"
module dmc_refresh_timer
  import dmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // configuration
  dmc_cfg_if.timer cfg
);
  typedef struct packed {
    logic [10:0] cnt;
    logic        pulse;
  } dmc_timer_s;

  dmc_timer_s q_reg;
  dmc_timer_s q_next;
  logic [10:0] lim;

  always_comb
  begin
    lim    = 11'h0;
    q_next = q_reg;
    q_next.pulse = 1'b0;
    case (cfg.refreshRate)
      `DMC_RATE_50: lim = 11'(`DMC_REF_CYCLES(50));
      `DMC_RATE_60: lim = 11'(`DMC_REF_CYCLES(60));
      `DMC_RATE_66: lim = 11'(`DMC_REF_CYCLES(66));
      default:      lim = 11'h0;
    endcase
    // off and reserved codes both stop refresh; data will decay
    if (lim == 11'h0)
      q_next.cnt = 11'h0;
    else if (q_reg.cnt >= lim - 11'h1)
    begin
      q_next.cnt   = 11'h0;
      q_next.pulse = 1'b1;
    end
    else
      q_next.cnt = q_reg.cnt + 11'h1;
    if (reset)
      q_next = '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset || clkEn)
      q_reg <= q_next;
  end

  assign cfg.refreshPulse = q_reg.pulse;
endmodule

// file: logic/dmc_addr_mux.sv
// row and column address split of a host address
// assumes the address is held stable by the controller
`timescale 1ns/1ps
`include "dmc_consts.svh"
module dmc_addr_mux
  import dmc_pkg::*;
(
  // address in, row and column out
  dmc_cfg_if.mux cfg
);
  logic rowTop;

  // high density parts take a different host bit on row line 11
  assign rowTop = cfg.highDensity ? cfg.addr[`DMC_ROW11_HDM] :
                  cfg.addr[`DMC_ROW11_STD];
  // no remapping: a hole only blocks access, addresses stay put
  assign cfg.rowAddr = {rowTop,
                        cfg.addr[`DMC_ROW_LSB +: 11]};
  assign cfg.colAddr = cfg.addr[`DMC_COL_LSB +: 12];
endmodule

// file: verif/dmc_mode_ctrl_chk.sv
// port assertions of the dram mode control block
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module dmc_mode_ctrl_chk
#(
  parameter int AW = 10
)
(
  // clock and reset
  input wire logic          clk,
  input wire logic          reset,
  // register bus
  input wire logic [AW-1:0] avsAddress,
  input wire logic          avsRead,
  input wire logic          avsWrite,
  input wire logic [31:0]   avsWritedata,
  input wire logic [3:0]    avsByteenable,
  input wire logic [31:0]   avsReaddata,
  input wire logic          avsWaitrequest,
  // host and pci results
  input wire logic          hostDone,
  input wire logic          hostToPci,
  input wire logic          specCancel,
  input wire logic          pciReq,
  input wire logic          pciDramHit,
  input wire logic          pciDevsel,
  // dram strobes and pads
  input wire logic          rasN,
  input wire logic          casN,
  input wire logic          memoryWriteEnableN,
  input wire logic          memoryDataLinesOeN,
  input wire logic          lowAddrDrive12mA,
  input wire logic          upperAddrDrive12mA,
  input wire logic          edoDetectTiming
);
  localparam logic [AW-1:0] EXT_ADR = AW'(12'h158);
  localparam logic [AW-1:0] CTL_ADR = AW'(12'h15c);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitrequest
    |=> !avsWaitrequest ##1 avsWaitrequest) else $error("bus answer late");
  pad_drive_a: assert property (
    avsWrite && !avsWaitrequest && avsByteenable[0] && avsAddress == EXT_ADR
    |=> ##[0:1] {lowAddrDrive12mA, upperAddrDrive12mA} ==
    $past(avsWritedata[2:1])) else $error("drive strength pads wrong");
  edo_mode_a: assert property (
    avsWrite && !avsWaitrequest && avsByteenable[0] && avsAddress == CTL_ADR
    |=> ##[0:1] edoDetectTiming == $past(avsWritedata[3]))
    else $error("edo detect timing wrong");
  ext_reserved_a: assert property (
    avsRead && !avsWaitrequest && avsAddress == EXT_ADR
    |-> avsReaddata[31:5] == 27'h0) else $error("ext reserved bits set");
  ctl_reserved_a: assert property (
    avsRead && !avsWaitrequest && avsAddress == CTL_ADR
    |-> avsReaddata[31:8] == 24'h0 && avsReaddata[5:4] == 2'h0)
    else $error("ctrl reserved bits set");
  pci_claim_a: assert property (
    pciDevsel |-> $past(pciReq) && $past(pciDramHit))
    else $error("devsel without dram request");
  spec_abort_a: assert property (
    specCancel |-> rasN && casN && !hostDone)
    else $error("aborted cycle left strobes active");
  pci_forward_a: assert property (
    hostToPci |-> rasN && !hostDone) else $error("forwarded cycle hit dram");
  turn_gap_a: assert property (
    $fell(memoryDataLinesOeN) |-> !memoryWriteEnableN &&
    $past(memoryWriteEnableN) == 1'b0) else $error("data driven too early");
  cbr_order_a: assert property (
    $fell(casN) && rasN |=> !rasN ##1 (rasN && casN))
    else $error("refresh strobe order wrong");
endmodule

bind dmc_mode_ctrl dmc_mode_ctrl_chk #(.AW(AW)) dmc_mode_ctrl_chk_i (
  .clk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
  .avsByteenable, .avsReaddata, .avsWaitrequest, .hostDone, .hostToPci,
  .specCancel, .pciReq, .pciDramHit, .pciDevsel, .rasN, .casN,
  .memoryWriteEnableN, .memoryDataLinesOeN, .lowAddrDrive12mA,
  .upperAddrDrive12mA, .edoDetectTiming);

// file: verif/dmc_dram_model.sv
// dram module model: one stored word, edo style read data hold
// assumes strobes and data come from the controller on one clock
`timescale 1ns/1ps
module dmc_dram_model
#(
  parameter int DW = 64
)
(
  // clock
  input  wire logic          clk,
  // strobes and data from the controller
  input  wire logic          rasN,
  input  wire logic          casN,
  input  wire logic          memoryWriteEnableN,
  input  wire logic [DW-1:0] memoryDataLinesOut,
  input  wire logic          memoryDataLinesOeN,
  // data back to the controller
  output logic      [DW-1:0] memoryDataLinesIn
);
  logic [DW-1:0] word = '0;
  logic [DW-1:0] junk = '0;
  logic          drive = 1'b0;
  // released lines toggle so a stale word never passes for read data
  assign memoryDataLinesIn = (drive || (!casN && !rasN && memoryWriteEnableN))
                             ? word : junk;
  always @(posedge clk)
  begin
    junk <= ~junk;
    if (!memoryDataLinesOeN && !memoryWriteEnableN)
      word <= memoryDataLinesOut;
    if (rasN)
      drive <= 1'b0;
    else if (!casN && memoryWriteEnableN)
      drive <= 1'b1;
  end
endmodule

// file: verif/dmc_mode_ctrl_tb.sv
// self-checking bench of the dram mode control block
// assumes the checker binds itself and the dram model answers reads
`timescale 1ns/1ps
module dmc_mode_ctrl_tb;
  import dmc_pkg::*;
  typedef struct {
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [2:0] p;
  } dmc_row_s;
  logic        clk, reset, clkEn, avsRead, avsWrite, avsWaitrequest;
  logic [9:0]  avsAddress;
  logic [31:0] avsWritedata, avsReaddata, hostAddr, pciAddr;
  logic [3:0]  avsByteenable;
  logic        hostReq, hostWrite, decodeDone, hostDone, hostToPci;
  logic        specCancel, pciReq, pciDramHit, pciDevsel, hit, row11;
  logic        hostAddressStrapLine, rasN, casN, casPrev;
  logic        memoryWriteEnableN, memoryDataLinesOeN, edoDetectTiming;
  logic        lowAddrDrive12mA, upperAddrDrive12mA;
  logic [63:0] hostWdata, hostRdata, memoryDataLinesIn, memoryDataLinesOut;
  logic [11:2] memoryAddressLines;
  logic [1:0]  lowAddrCopyA, lowAddrCopyB;
  logic [3:0]  rowLow;
  logic [7:0]  q;
  logic [2:0]  pads;
  dmc_target_e decodeTarget;
  int          nErrors, testsRun, cyc, c0, d0, nRef, tRef, tPrev;
  int          tDone, tPci, tCan, tDev, tRas, tWe, tOe;
  int          mhz [4] = '{0, 50, 60, 66};
  logic [31:0] hAdr [5] = '{32'h0008_0000, 32'h0009_fff8, 32'h000a_0000,
                            32'h00f0_0000, 32'h00ff_fff8};
  dmc_row_s    rows [8] = '{
    '{10'h158, 8'hff, 8'h1f, 3'b110}, '{10'h158, 8'he4, 8'h04, 3'b100},
    '{10'h158, 8'h02, 8'h02, 3'b010}, '{10'h15c, 8'hf8, 8'hc8, 3'b011},
    '{10'h15c, 8'h33, 8'h03, 3'b010}, '{10'h158, 8'h00, 8'h00, 3'b000},
    '{10'h160, 8'hff, 8'h00, 3'b000}, '{10'h15c, 8'h00, 8'h00, 3'b000}};
  assign pads = {lowAddrDrive12mA, upperAddrDrive12mA, edoDetectTiming};

  dmc_mode_ctrl dmc_mode_ctrl_i (.clk, .reset, .clkEn, .avsAddress, .avsRead,
    .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
    .hostReq, .hostAddr, .hostWrite, .hostWdata, .decodeDone, .decodeTarget,
    .hostDone, .hostRdata, .hostToPci, .specCancel, .pciReq, .pciAddr,
    .pciDramHit, .pciDevsel, .hostAddressStrapLine, .memoryAddressLines,
    .lowAddrCopyA, .lowAddrCopyB, .rasN, .casN, .memoryWriteEnableN,
    .memoryDataLinesIn, .memoryDataLinesOut, .memoryDataLinesOeN,
    .lowAddrDrive12mA, .upperAddrDrive12mA, .edoDetectTiming);
  dmc_dram_model dmc_dram_model_i (.clk, .rasN, .casN, .memoryWriteEnableN,
    .memoryDataLinesOut, .memoryDataLinesOeN, .memoryDataLinesIn);

  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    testsRun++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      nErrors++;
    end
  endtask

  task automatic summarize();
    if (nErrors == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one idle edge after release, so two calls never drive one step twice
  task automatic bus(logic w, logic [9:0] a, logic [7:0] d);
    int i;
    avsAddress <= a;
    avsWritedata <= {24'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (avsWaitrequest !== 1'b0 && i < 40);
    q = avsReaddata[7:0];
    if (i >= 40)
    begin
      nErrors++;
      summarize();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic host(logic [31:0] a, logic w, dmc_target_e t);
    {tDone, tPci, tCan, tDev, tRas, tWe, tOe} = {7{32'hffff_ffff}};
    hostAddr <= a;
    pciAddr <= a;
    hostWrite <= w;
    decodeTarget <= t;
    pciDramHit <= (t == DMC_TGT_DRAM);
    hostReq <= 1'b1;
    pciReq <= 1'b1;
    @(posedge clk);
    c0 = cyc;
    hostReq <= 1'b0;
    pciReq <= 1'b0;
    decodeDone <= 1'b1;
    @(posedge clk);
    decodeDone <= 1'b0;
    repeat (30) @(posedge clk);
  endtask

  task automatic rst(logic s);
    hostAddressStrapLine <= s;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    casPrev <= casN;
    if (hostDone === 1'b1) tDone <= cyc;
    if (hostToPci === 1'b1) tPci <= cyc;
    if (specCancel === 1'b1) tCan <= cyc;
    if (pciDevsel === 1'b1) tDev <= cyc;
    if (memoryWriteEnableN === 1'b0 && tWe < 0) tWe <= cyc;
    if (memoryDataLinesOeN === 1'b0 && tOe < 0) tOe <= cyc;
    if (rasN === 1'b0 && tRas < 0)
    begin
      tRas <= cyc;
      row11 <= memoryAddressLines[11];
      rowLow <= {lowAddrCopyA, lowAddrCopyB};
    end
    if (casN === 1'b0 && casPrev === 1'b1 && rasN === 1'b1)
    begin
      nRef <= nRef + 1;
      tPrev <= tRef;
      tRef <= cyc;
    end
  end

  initial
  begin
    {reset, clkEn, avsRead, avsWrite, hostReq, hostWrite} = 6'b110000;
    {decodeDone, pciReq, pciDramHit, hostAddressStrapLine} = 4'b0001;
    {avsAddress, avsWritedata, hostAddr, pciAddr} = '0;
    {cyc, nErrors, testsRun, nRef, tRef, tPrev, casPrev} = '0;
    avsByteenable = 4'hf;
    hostWdata = 64'h0123_4567_89ab_cdef;
    decodeTarget = DMC_TGT_DRAM;
    @(posedge clk);
    rst(1'b1);
    bus(1'b0, 10'h15c, 8'h00);
    chk("ctrl strap high", 8'h00, q);
    // rows leave the rate at zero so refresh stays out of host cycles
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      chk("reg", rows[i].q, q);
      chk("pads", rows[i].p, pads);
    end
    host(32'h0801_8000, 1'b0, DMC_TGT_DRAM);
    chk("row11 std", 1'b0, row11);
    chk("row low copies", 4'hf, rowLow);
    bus(1'b1, 10'h158, 8'h01);
    host(32'h0800_0000, 1'b0, DMC_TGT_DRAM);
    chk("row11 hdm", 1'b1, row11);
    bus(1'b1, 10'h158, 8'h00);
    host(32'h0000_1000, 1'b1, DMC_TGT_DRAM);
    chk("turn legacy", 1, tOe - tWe);
    bus(1'b1, 10'h158, 8'h08);
    host(32'h0000_1000, 1'b1, DMC_TGT_DRAM);
    chk("turn extra", 2, tOe - tWe);
    bus(1'b1, 10'h158, 8'h00);
    host(32'h0000_1000, 1'b0, DMC_TGT_DRAM);
    d0 = tDone - c0;
    chk("rdata", hostWdata, hostRdata);
    bus(1'b1, 10'h15c, 8'h08);
    host(32'h0000_1000, 1'b0, DMC_TGT_DRAM);
    chk("edo read", d0 + 1, tDone - c0);
    bus(1'b1, 10'h15c, 8'h00);
    bus(1'b1, 10'h158, 8'h10);
    host(32'h0000_1000, 1'b0, DMC_TGT_DRAM);
    chk("leadoff", d0 - 1, tDone - c0);
    for (int t = 0; t < 2; t++)
    begin
      host(32'h0000_1000, 1'b0,
           dmc_target_e'(t ? DMC_TGT_PCI : DMC_TGT_CACHE));
      chk("cancel", 1, tCan >= 0);
      chk("cancel fwd", t, tPci >= 0);
      chk("cancel done", 0, tDone >= 0);
    end
    bus(1'b1, 10'h158, 8'h00);
    for (int h = 0; h < 4; h++)
    begin
      bus(1'b1, 10'h15c, {h[1:0], 6'h00});
      foreach (hAdr[j])
      begin
        hit = (h == 1 && hAdr[j] >= 32'h8_0000 && hAdr[j] < 32'ha_0000) ||
              (h == 2 && hAdr[j] >= 32'hf0_0000 && hAdr[j] < 32'h100_0000);
        host(hAdr[j], 1'b0, DMC_TGT_DRAM);
        chk("hole fwd", hit, tPci >= 0);
        chk("hole done", !hit, tDone >= 0);
        chk("hole devsel", !hit, tDev >= 0);
      end
    end
    for (int r = 0; r < 5; r++)
    begin
      bus(1'b1, 10'h15c, 8'(r));
      nRef = 0;
      for (int i = 0; i < 3300 && nRef < 3; i++)
        @(posedge clk);
      chk("ref count", (r % 4) ? 3 : 0, nRef);
      if (r % 4)
        chk("ref gap", (15600 * mhz[r]) / 1000, tRef - tPrev);
    end
    rst(1'b0);
    bus(1'b0, 10'h15c, 8'h00);
    chk("ctrl reset", 8'h01, q);
    bus(1'b0, 10'h158, 8'h00);
    chk("ext reset", 8'h00, q);
    summarize();
  end
endmodule
